/* hdl/tsa_core.sv */
// Purpose: touch sense acquisition sequencer, pad control and AHB-Lite registers
// Assumes: pad levels and the sync pin arrive asynchronously; low-power request is on clk
// Notes: pulse timing is fixed; group counters are visible after each acquisition
`timescale 1ns/1ps
`default_nettype none

// Function
// - idle: all pins default; acquiring: unused default
// - default: push-pull low or input floating
// - pin neither electrode nor capacitor is unused
// - several channels per group acquire together
// - selected pins' analog switch driven during acquisition
// - normal mode starts on start bit
// - synchronized mode waits for trigger pin
// - only enabled groups count and decide end
// - disabled groups' channels still pulsed
// - threshold crossing sets group done bit
// - all enabled done sets end flag, irq
// - max count stops, sets both flags
// - unfinished groups stay not done after error
// - clear register bits clear matching flags
// - counters cleared at start, loaded at end
// - enabled controller overrides hysteresis and switch
// - sleep harmless, interrupt wakes system
// - stop or standby freezes registers and operation
// - max count encoding selects pulse limit
// - hardware clears start; software clear cancels
// - polarity: falling edge or high level
module tsa_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] pad_in,
  input wire logic sync_pin,
  input wire logic lp_freeze,
  output tsa_pkg::tsa_pin_t [31:0] pad,
  output logic acq_busy,
  output logic irq
);

  // bus address phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  wire addr_phase = hsel & hready & htrans[1];
  wire [7:0] rd_addr = haddr[7:0];

  // software registers
  logic [31:0] ctrl;
  logic [1:0] ien;
  logic [31:0] hyst;
  logic [31:0] asw;
  logic [31:0] scap;
  logic [31:0] chan;
  logic [7:0] gen;
  logic eoa_flag;
  logic mce_flag;

  // sequencer state
  tsa_pkg::tsa_state_t state;
  logic [tsa_pkg::PH_W-1:0] ph_cnt;
  logic [7:0] done;
  logic [tsa_pkg::CNT_W-1:0] live [0:7];
  logic [tsa_pkg::CNT_W-1:0] gcnt [0:7];

  // synchronisers
  logic [31:0] pad_s1;
  logic [31:0] pad_s2;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;

  // control fields
  wire en = ctrl[tsa_pkg::CTRL_EN];
  wire start = ctrl[tsa_pkg::CTRL_START];
  wire sync_mode = ctrl[tsa_pkg::CTRL_MODE];
  wire spol = ctrl[tsa_pkg::CTRL_SPOL];
  wire io_default_mode = ctrl[tsa_pkg::CTRL_IO_DEFAULT_MODE];
  wire [2:0] max_count_value = ctrl[tsa_pkg::CTRL_MCV_LSB +: 3];
  wire [tsa_pkg::CNT_W-1:0] limit = tsa_pkg::MCV_LIMIT[max_count_value];

  // write strobes, all blocked while frozen
  wire wr_ok = wr_pend & ~lp_freeze;
  wire wr_ctrl = wr_ok & (wr_addr == tsa_pkg::OFF_CTRL);
  wire wr_ien = wr_ok & (wr_addr == tsa_pkg::OFF_IEN);
  wire wr_iclr = wr_ok & (wr_addr == tsa_pkg::OFF_ICLR);
  wire wr_hyst = wr_ok & (wr_addr == tsa_pkg::OFF_HYST);
  wire wr_asw = wr_ok & (wr_addr == tsa_pkg::OFF_ASW);
  wire wr_scap = wr_ok & (wr_addr == tsa_pkg::OFF_SCAP);
  wire wr_chan = wr_ok & (wr_addr == tsa_pkg::OFF_CHAN);
  wire wr_gcs = wr_ok & (wr_addr == tsa_pkg::OFF_GCS);
  wire clr_eoa = wr_iclr & hwdata[tsa_pkg::FLG_EOA];
  wire clr_mce = wr_iclr & hwdata[tsa_pkg::FLG_MCE];

  // sequencer decode
  wire run = ~lp_freeze;
  wire acq_on = (state != tsa_pkg::ST_IDLE) && (state != tsa_pkg::ST_ARMED);
  wire abort = (state != tsa_pkg::ST_IDLE) & (~start | ~en);
  wire trig = spol ? sync_s2 : (sync_s3 & ~sync_s2);
  // go marks the real start: straight from idle in normal mode, on the trigger when armed
  wire go = ~abort & (((state == tsa_pkg::ST_IDLE) & en & start & ~sync_mode) |
                      ((state == tsa_pkg::ST_ARMED) & trig));
  wire ph_last = (ph_cnt == '0);
  wire measure = run & ~abort & (state == tsa_pkg::ST_MEASURE);

  // per group threshold, pulse count and error decode
  logic [7:0] hit;
  logic [7:0] next_done;
  logic [7:0] over;
  wire err = measure & (|over);
  wire all_done = &(next_done | ~gen);
  wire acq_end = measure & (err | all_done);
  genvar g;
  generate
    for (g = 0; g < tsa_pkg::NUM_GRP; g++) begin : grp
      wire [tsa_pkg::CNT_W-1:0] inc = live[g] + 14'h0001;
      assign hit[g] = |(pad_s2[g*4 +: 4] & scap[g*4 +: 4]);
      assign next_done[g] = done[g] | (gen[g] & hit[g]);
      assign over[g] = gen[g] & ~next_done[g] & (inc >= limit);
      always_ff @(posedge clk) begin
        if (rst) begin
          live[g] <= '0;
          gcnt[g] <= '0;
        end else if (run) begin
          if (go) begin
            live[g] <= '0;
            gcnt[g] <= '0;
          end else if (measure && gen[g] && !done[g]) begin
            live[g] <= inc;
          end
          if (acq_end) begin
            gcnt[g] <= (gen[g] && !done[g]) ? inc : live[g];
          end
        end
      end
    end
  endgenerate

  // read multiplexer; unmapped words read zero
  wire [3:0] cidx = 4'(rd_addr[5:2] - 4'h9);
  wire is_cnt = (rd_addr >= tsa_pkg::OFF_GCNT0) && (rd_addr < 8'h44) && (rd_addr[1:0] == 2'h0);
  wire [31:0] gcs_val = {8'h00, done, 8'h00, gen};
  wire [31:0] isr_val = {30'h0, mce_flag, eoa_flag};
  wire [31:0] rd_val =
    (rd_addr == tsa_pkg::OFF_CTRL) ? ctrl :
    (rd_addr == tsa_pkg::OFF_IEN) ? {30'h0, ien} :
    (rd_addr == tsa_pkg::OFF_ISTAT) ? isr_val :
    (rd_addr == tsa_pkg::OFF_HYST) ? hyst :
    (rd_addr == tsa_pkg::OFF_ASW) ? asw :
    (rd_addr == tsa_pkg::OFF_SCAP) ? scap :
    (rd_addr == tsa_pkg::OFF_CHAN) ? chan :
    (rd_addr == tsa_pkg::OFF_GCS) ? gcs_val :
    is_cnt ? {18'h0, gcnt[cidx[2:0]]} : 32'h0000_0000;

  // bus capture and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // bus answers at once and always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // control register; hardware drops start at the end of an acquisition
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= tsa_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= hwdata & tsa_pkg::CTRL_MASK;
    end else if (acq_end) begin
      ctrl[tsa_pkg::CTRL_START] <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ien <= tsa_pkg::IEN_RST;
      hyst <= tsa_pkg::HYST_RST;
      asw <= tsa_pkg::ASW_RST;
      scap <= tsa_pkg::SEL_RST;
      chan <= tsa_pkg::SEL_RST;
      gen <= tsa_pkg::GEN_RST;
    end else begin
      if (wr_ien) ien <= hwdata[1:0];
      if (wr_hyst) hyst <= hwdata;
      if (wr_asw) asw <= hwdata;
      if (wr_scap) scap <= hwdata;
      if (wr_chan) chan <= hwdata;
      if (wr_gcs) gen <= hwdata[7:0];
    end
  end

  // interrupt flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      eoa_flag <= 1'b0;
      mce_flag <= 1'b0;
    end else begin
      if (acq_end) begin
        eoa_flag <= 1'b1;
      end else if (clr_eoa) begin
        eoa_flag <= 1'b0;
      end
      if (err) begin
        mce_flag <= 1'b1;
      end else if (clr_mce) begin
        mce_flag <= 1'b0;
      end
    end
  end

  // interrupt request stays a level so it can wake the core from sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (run) begin
      irq <= (eoa_flag & ien[tsa_pkg::FLG_EOA]) | (mce_flag & ien[tsa_pkg::FLG_MCE]);
    end
  end

  // sequencer: discharge, then charge / dead / transfer / dead / measure per pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= tsa_pkg::ST_IDLE;
      ph_cnt <= '0;
      done <= 8'h00;
    end else if (run) begin
      if (abort) begin
        state <= tsa_pkg::ST_IDLE;
      end else begin
        unique case (state)
          tsa_pkg::ST_IDLE: begin
            if (en && start) begin
              done <= 8'h00;
              state <= sync_mode ? tsa_pkg::ST_ARMED : tsa_pkg::ST_DISCH;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::DISCH_CYC - 1);
            end
          end
          tsa_pkg::ST_ARMED: begin
            if (trig) begin
              state <= tsa_pkg::ST_DISCH;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::DISCH_CYC - 1);
            end
          end
          tsa_pkg::ST_DISCH: begin
            ph_cnt <= ph_cnt - 8'h01;
            if (ph_last) begin
              state <= tsa_pkg::ST_CHARGE;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::CHARGE_CYC - 1);
            end
          end
          tsa_pkg::ST_CHARGE: begin
            ph_cnt <= ph_cnt - 8'h01;
            if (ph_last) begin
              state <= tsa_pkg::ST_DEAD1;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::DEAD_CYC - 1);
            end
          end
          tsa_pkg::ST_DEAD1: begin
            ph_cnt <= ph_cnt - 8'h01;
            if (ph_last) begin
              state <= tsa_pkg::ST_XFER;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::XFER_CYC - 1);
            end
          end
          tsa_pkg::ST_XFER: begin
            ph_cnt <= ph_cnt - 8'h01;
            if (ph_last) begin
              state <= tsa_pkg::ST_DEAD2;
              ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::DEAD_CYC - 1);
            end
          end
          tsa_pkg::ST_DEAD2: begin
            ph_cnt <= ph_cnt - 8'h01;
            if (ph_last) begin
              state <= tsa_pkg::ST_MEASURE;
            end
          end
          tsa_pkg::ST_MEASURE: begin
            // an error leaves unfinished groups not done
            done <= next_done;
            ph_cnt <= tsa_pkg::PH_W'(tsa_pkg::CHARGE_CYC - 1);
            state <= acq_end ? tsa_pkg::ST_IDLE : tsa_pkg::ST_CHARGE;
          end
        endcase
      end
    end
  end

  // synchronisers for pad levels and the trigger pin
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_s1 <= 32'h0000_0000;
      pad_s2 <= 32'h0000_0000;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
      sync_s1 <= sync_pin;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  // busy flag for the system
  always_ff @(posedge clk) begin
    if (rst) begin
      acq_busy <= 1'b0;
    end else if (run) begin
      acq_busy <= acq_on & ~abort;
    end
  end

  // pad drive per pin
  wire ph_disch = (state == tsa_pkg::ST_DISCH);
  wire ph_charge = (state == tsa_pkg::ST_CHARGE);
  wire ph_xfer = (state == tsa_pkg::ST_XFER);
  genvar p;
  generate
    for (p = 0; p < tsa_pkg::NUM_PIN; p++) begin : pin
      wire is_cap = scap[p];
      wire is_ch = chan[p];
      wire used = is_cap | is_ch;
      wire act = acq_on & used;
      wire d_oe = act ? ((is_cap & ph_disch) | (is_ch & ph_charge)) : ~io_default_mode;
      wire d_out = act & is_ch & ph_charge;
      wire d_sw = act ? (ph_disch | ph_xfer) : asw[p];
      always_ff @(posedge clk) begin
        if (rst) begin
          pad[p] <= '0;
        end else if (run) begin
          pad[p].own <= en;
          pad[p].oe <= en & d_oe;
          pad[p].out <= en & d_out;
          pad[p].sw <= en & d_sw;
          pad[p].hyst <= en ? hyst[p] : 1'b1;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* shared/tsa_pkg.sv */
// Purpose: shared constants and types for the touch sense acquisition block
// Assumes: 8 analog groups of 4 pins, registers on AHB-Lite, 100 MHz clock
// Notes: offsets are byte addresses of aligned 32-bit words
package tsa_pkg;
  // geometry
  localparam int NUM_GRP = 8;
  localparam int PIN_PER_GRP = 4;
  localparam int NUM_PIN = 32;
  localparam int CNT_W = 14;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IEN = 8'h04;
  localparam logic [7:0] OFF_ICLR = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0c;
  localparam logic [7:0] OFF_HYST = 8'h10;
  localparam logic [7:0] OFF_ASW = 8'h14;
  localparam logic [7:0] OFF_SCAP = 8'h18;
  localparam logic [7:0] OFF_CHAN = 8'h1c;
  localparam logic [7:0] OFF_GCS = 8'h20;
  localparam logic [7:0] OFF_GCNT0 = 8'h24;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_SPOL = 3;
  localparam int CTRL_IO_DEFAULT_MODE = 4;
  localparam int CTRL_MCV_LSB = 5;
  localparam logic [31:0] CTRL_MASK = 32'hffff_f0ff;
  // flag positions, shared by enable, clear and status registers
  localparam int FLG_EOA = 0;
  localparam int FLG_MCE = 1;
  localparam int GCS_DONE_LSB = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] IEN_RST = 2'h0;
  localparam logic [31:0] HYST_RST = 32'hffff_ffff;
  localparam logic [31:0] ASW_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [7:0] GEN_RST = 8'h00;
  // pulse limits selected by max_count_value, the last code is reserved
  localparam logic [CNT_W-1:0] MCV_LIMIT [0:7] = '{14'h00ff, 14'h01ff, 14'h03ff, 14'h07ff,
                                                  14'h0fff, 14'h1fff, 14'h3fff, 14'h3fff};
  // timing
  localparam int CLK_NS = 10;
  localparam int CHARGE_NS = 500;
  localparam int XFER_NS = 500;
  localparam int DISCH_NS = 1000;
  localparam int DEAD_CYC = 2;
  localparam int CHARGE_CYC = (CHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_CYC = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int DISCH_CYC = (DISCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PH_W = 8;
  // acquisition sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_DISCH, ST_CHARGE, ST_DEAD1, ST_XFER, ST_DEAD2, ST_MEASURE
  } tsa_state_t;
  // drive of one pad
  typedef struct packed {
    logic own;
    logic out;
    logic oe;
    logic sw;
    logic hyst;
  } tsa_pin_t;
endpackage

/* sim/tsa_checker.sv */
// Purpose: port checks for tsa_core
// Assumes: pin 0 is the capacitor, pins 1, 2 and 4 are channels
// Notes: pad fields lag the sequencer state by one cycle
`timescale 1ns/1ps
`default_nettype none
module tsa_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic lp_freeze,
  input wire tsa_pkg::tsa_pin_t [31:0] pad,
  input wire logic acq_busy,
  input wire logic irq
);
  logic [31:0] own_v, out_v, oe_v, sw_v, hy_v;
  // split pad fields into vectors
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      {own_v[i], out_v[i], oe_v[i], sw_v[i], hy_v[i]} = pad[i];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // idle pins sit in the default state
  property p_idle_low;
    !acq_busy && !$past(acq_busy) |-> out_v == 32'h0;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle pin high");
  property p_idle_same;
    !acq_busy && !$past(acq_busy) |-> oe_v == 32'h0 || oe_v == 32'hffffffff;
  endproperty
  a_idle_same: assert property (p_idle_same) else $error("idle pins differ");
  property p_off;
    !$past(rst) |-> (~own_v & (oe_v | out_v | sw_v | ~hy_v)) == 32'h0;
  endproperty
  a_off: assert property (p_off) else $error("disabled pad not released");
  property p_drive;
    (out_v & ~oe_v) == 32'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("high without drive");
  // charge pulse on a disabled group channel
  property p_pulse;
    $rose(out_v[4]) |-> ##49 out_v[4] ##1 !out_v[4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("charge length");
  property p_chan_same;
    out_v[1] == out_v[2] && out_v[2] == out_v[4];
  endproperty
  a_chan_same: assert property (p_chan_same) else $error("channels apart");
  property p_freeze;
    $past(lp_freeze) |-> $stable(pad) && $stable(acq_busy) && $stable(irq);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved in freeze");
  property p_start;
    $rose(acq_busy) |-> ##[0:2] own_v[0];
  endproperty
  a_start: assert property (p_start) else $error("busy while off");
  property p_disch;
    $rose(acq_busy) |-> ##[1:2] (sw_v[0] && oe_v[0] && !out_v[0]);
  endproperty
  a_disch: assert property (p_disch) else $error("no discharge");
  c_acq: cover property ($rose(acq_busy));
  c_irq: cover property ($rose(irq));
  c_frz: cover property ($rose(lp_freeze));
endmodule
bind tsa_core tsa_checker u_chk (.clk(clk), .rst(rst), .lp_freeze(lp_freeze), .pad(pad),
  .acq_busy(acq_busy), .irq(irq));
`default_nettype wire

/* sim/tsa_pads.sv */
// Purpose: pad model, pin 0 capacitor filled by pin 1 charge pulses
// Assumes: threshold is crossed after target pulses
// Notes: all inputs other than pin 0 toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module tsa_pads (
  input wire logic clk,
  input wire tsa_pkg::tsa_pin_t [31:0] pad,
  input wire logic [13:0] target,
  output logic [31:0] pad_in
);
  logic [14:0] fill = 15'h0;
  logic last_hi = 1'b0;
  logic wiggle = 1'b0;
  // count charge pulses, empty on discharge
  always @(posedge clk) begin
    last_hi <= pad[1].out;
    wiggle <= ~wiggle;
    if (pad[0].oe && !pad[0].out) begin
      fill <= 15'h0;
    end else if (pad[1].out && !last_hi && fill != 15'h7fff) begin
      fill <= fill + 15'h1;
    end
  end
  // capacitor level against threshold
  assign pad_in = {{31{wiggle}}, fill >= {1'b0, target}};
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Purpose: self-checking bench for tsa_core
// Assumes: pin 0 capacitor, pins 1, 2, 4 channels, group 0 enabled
// Notes: fill target drawn at random from seed 96
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sync_pin = 1'b0;
  logic lp_freeze = 1'b0;
  logic [13:0] target = 14'h5;
  logic hreadyout, hresp, acq_busy, irq;
  logic saw4 = 1'b0;
  logic [31:0] hrdata, pad_in, rd;
  tsa_pkg::tsa_pin_t [31:0] pad;
  int error_cnt = 0;
  int checks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  tsa_core dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pad_in(pad_in), .sync_pin(sync_pin), .lp_freeze(lp_freeze), .pad(pad),
    .acq_busy(acq_busy), .irq(irq));
  tsa_pads u_pads (.clk(clk), .pad(pad), .target(target), .pad_in(pad_in));
  // note pulses on the disabled group channel
  always @(posedge clk) begin
    if (acq_busy && pad[4].out) saw4 <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && acq_busy !== v; i++) @(posedge clk);
  endtask
  function automatic logic [31:0] lim(input logic [2:0] c);
    return (c == 3'h7) ? 32'h3fff : ((32'h100 << c) - 32'h1);
  endfunction
  function automatic logic [31:0] ctl(input logic st, input logic md, input logic sp, input logic [2:0] mc);
    return {24'h0, mc, 1'b0, sp, md, st, 1'b1};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(96));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(tsa_pkg::OFF_CTRL, 32'h0);
    rd_chk(tsa_pkg::OFF_HYST, 32'hffffffff);
    rd_chk(8'h80, 32'h0);
    wr(tsa_pkg::OFF_HYST, 32'h0);
    wr(tsa_pkg::OFF_CTRL, 32'h11);
    repeat (3) @(posedge clk);
    check({27'h0, pad[0]}, 32'h10);
    wr(tsa_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    check({27'h0, pad[0]}, 32'h14);
    wr(tsa_pkg::OFF_SCAP, 32'h1);
    wr(tsa_pkg::OFF_CHAN, 32'h16);
    wr(tsa_pkg::OFF_GCS, 32'h1);
    wr(tsa_pkg::OFF_IEN, 32'h3);
    target <= 14'($urandom_range(12, 3));
    wr(tsa_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h6));
    repeat (3) @(posedge clk);
    check({31'h0, acq_busy}, 32'h1);
    wait_busy(1'b0, 3000);
    repeat (3) @(posedge clk);
    rd_chk(tsa_pkg::OFF_ISTAT, 32'h1);
    rd_chk(tsa_pkg::OFF_GCS, 32'h10001);
    rd_chk(tsa_pkg::OFF_GCNT0, {18'h0, target});
    rd_chk(tsa_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 3'h6));
    check({31'h0, irq}, 32'h1);
    check({31'h0, saw4}, 32'h1);
    wr(tsa_pkg::OFF_ICLR, 32'h1);
    @(posedge clk);
    rd_chk(tsa_pkg::OFF_ISTAT, 32'h0);
    // capacitor never fills: smallest limit ends the run
    target <= 14'h3fff;
    wr(tsa_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h0));
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 30000);
    repeat (3) @(posedge clk);
    rd_chk(tsa_pkg::OFF_ISTAT, 32'h3);
    rd_chk(tsa_pkg::OFF_GCS, 32'h1);
    rd_chk(tsa_pkg::OFF_GCNT0, lim(3'h0));
    wr(tsa_pkg::OFF_ICLR, 32'h3);
    @(posedge clk);
    rd_chk(tsa_pkg::OFF_ISTAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    // trigger of each polarity, then cancel
    for (int p = 1; p >= 0; p--) begin
      sync_pin <= ~p[0];
      repeat (5) @(posedge clk);
      wr(tsa_pkg::OFF_CTRL, ctl(1'b1, 1'b1, p[0], 3'h6));
      repeat (20) @(posedge clk);
      check({31'h0, acq_busy}, 32'h0);
      sync_pin <= p[0];
      wait_busy(1'b1, 10);
      check({31'h0, acq_busy}, 32'h1);
      wr(tsa_pkg::OFF_CTRL, ctl(1'b0, 1'b1, p[0], 3'h6));
      repeat (3) @(posedge clk);
      check({31'h0, acq_busy}, 32'h0);
    end
    rd_chk(tsa_pkg::OFF_ISTAT, 32'h0);
    rd_chk(tsa_pkg::OFF_GCNT0, 32'h0);
    lp_freeze <= 1'b1;
    wr(tsa_pkg::OFF_CTRL, 32'h0);
    rd_chk(tsa_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 3'h6));
    lp_freeze <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
